// ---- rtl/adcseq_defines.svh ----
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH
`define ADCSEQ_OFS_RES_HIGH   4'h0
`define ADCSEQ_OFS_RES_LOW    4'h1
`define ADCSEQ_OFS_CTL_ZERO   4'h2
`define ADCSEQ_OFS_CTL_ONE    4'h3
`define ADCSEQ_OFS_CTL_TWO    4'h4
`define ADCSEQ_OFS_FLAGS      4'h5
`define ADCSEQ_OFS_ENABLES    4'h6
`define ADCSEQ_OFS_PRIORITY   4'h7
`define ADCSEQ_OFS_FLAG_CLR   4'h8
`define ADCSEQ_BIT_ENABLE     0
`define ADCSEQ_BIT_GO         1
`define ADCSEQ_BIT_JUSTIFY    7
`define ADCSEQ_BIT_DONE       6
`define ADCSEQ_BIT_ABORT      0
`define ADCSEQ_RST_CTL        8'h00
`define ADCSEQ_RST_PRIORITY   8'h7f
`define ADCSEQ_TRIG_MODE      4'hb
`define ADCSEQ_CONV_TADS      4'd12
`define ADCSEQ_ABORT_TADS     4'd2
`define ADCSEQ_CLK_PERIOD_NS  40
`define ADCSEQ_RC_PERIOD_NS   1000
`define ADCSEQ_RC_DIV \
    ((`ADCSEQ_RC_PERIOD_NS + `ADCSEQ_CLK_PERIOD_NS - 1) / `ADCSEQ_CLK_PERIOD_NS)
`endif

// ---- rtl/adcseq_pkg.sv ----
// Types of the conversion sequencer
package adcseq_pkg;
    typedef enum logic [1:0]
    {
        ADCSEQ_IDLE  = 2'b00,
        ADCSEQ_CONV  = 2'b01,
        ADCSEQ_WAIT  = 2'b11
    } adcseq_state_t;

    typedef struct packed
    {
        adcseq_state_t st;
        logic [3:0]    chan;
        logic          go;
        logic          en;
        logic [5:0]    ctl1;
        logic          just;
        logic [2:0]    clksel;
        logic [7:0]    res_hi;
        logic [7:0]    res_lo;
        logic [7:0]    flags;
        logic [7:0]    enables;
        logic [7:0]    prio;
        logic [6:0]    div_cnt;
        logic [3:0]    tad_idx;
        logic [9:0]    trial;
        logic [9:0]    mask;
        logic [2:0]    sync;
        logic          comp;
        logic          timer_clr;
        logic          irq;
        logic          sample;
        logic [7:0]    rdata;
    } adcseq_regs_t;
endpackage

// ---- rtl/adcseq_top.sv ----
// Conversion sequencer: registers, bit clock, SAR control, trigger and interrupt
// Function
// - Clearing the go flag during a conversion aborts it at once.
// - An aborted conversion leaves the result pair untouched.
// - After an abort two bit periods pass before acquisition resumes.
// - After that wait acquisition restarts on the selected channel by itself.
// - The compare trigger starts a conversion only in mode 1011 with the converter enabled.
// - The trigger sets the go flag and clears the timer counter in the same event.
// - With the converter disabled the trigger is ignored but still clears the timer.
// - The result is two bytes, high and low, changed only by writes, loads and reset.
// - A conversion lasts exactly twelve bit periods up to the result load.
// - At completion the result is loaded, go clears and the done flag sets.
// - The clock select field sets the bit period from the clock or the internal RC source.
// - Bit 7 of control two picks right or left justification of the result.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "adcseq_defines.svh"

module adcseq_top
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       TRIG,
    input  wire logic [3:0] COMPARE_MODE,
    output logic            TIMER_CLEAR,
    input  wire logic       COMP_IN,
    output logic      [9:0] DAC_CODE,
    output logic            SAMPLE,
    output logic      [3:0] CHANNEL,
    output logic            IRQ
);
    import adcseq_pkg::*;

    adcseq_regs_t r;
    adcseq_regs_t next_r;
    logic [6:0]   tad_div;
    logic         tick;
    logic         go_wr;
    logic         abort;
    logic [7:0]   clr_mask;

    // Bit period length in core clocks; RC codes use a fixed divider
    always_comb
    begin
        case (r.clksel)
            3'b000: tad_div = 7'd2;
            3'b100: tad_div = 7'd4;
            3'b001: tad_div = 7'd8;
            3'b101: tad_div = 7'd16;
            3'b010: tad_div = 7'd32;
            3'b110: tad_div = 7'd64;
            default: tad_div = 7'(`ADCSEQ_RC_DIV);
        endcase
    end

    assign tick = (r.div_cnt == tad_div - 7'd1);

    // All next-state logic in one place
    always_comb
    begin
        next_r = r;
        go_wr = 1'b0;
        abort = 1'b0;
        clr_mask = 8'h00;
        next_r.timer_clr = 1'b0;
        next_r.rdata = 8'h00;
        // Comparator is analog and asynchronous; settle on two agreeing taps
        next_r.sync = {r.sync[1:0], COMP_IN};
        if (r.sync[2] == r.sync[1])
        begin
            next_r.comp = r.sync[2];
        end
        next_r.div_cnt = tick ? 7'd0 : r.div_cnt + 7'd1;

        // Register writes
        if (WR)
        begin
            case (ADDR)
                `ADCSEQ_OFS_RES_HIGH: next_r.res_hi = WDATA;
                `ADCSEQ_OFS_RES_LOW:  next_r.res_lo = WDATA;
                `ADCSEQ_OFS_CTL_ZERO:
                begin
                    next_r.chan = WDATA[5:2];
                    next_r.en = WDATA[`ADCSEQ_BIT_ENABLE];
                    // Old enable gates go, so enable and go together start nothing
                    go_wr = WDATA[`ADCSEQ_BIT_GO] & r.en
                          & WDATA[`ADCSEQ_BIT_ENABLE];
                    next_r.go = go_wr;
                end
                `ADCSEQ_OFS_CTL_ONE:  next_r.ctl1 = WDATA[5:0];
                `ADCSEQ_OFS_CTL_TWO:
                begin
                    next_r.just = WDATA[`ADCSEQ_BIT_JUSTIFY];
                    next_r.clksel = WDATA[2:0];
                end
                `ADCSEQ_OFS_ENABLES:  next_r.enables = WDATA;
                `ADCSEQ_OFS_PRIORITY: next_r.prio = WDATA;
                `ADCSEQ_OFS_FLAG_CLR: clr_mask = WDATA;
                default: ;
            endcase
        end

        // Special event trigger from the compare unit
        if (TRIG && COMPARE_MODE == `ADCSEQ_TRIG_MODE)
        begin
            next_r.timer_clr = 1'b1;
            if (next_r.en)
            begin
                next_r.go = 1'b1;
            end
        end

        next_r.flags = r.flags & ~clr_mask;

        // Sequencer
        case (r.st)
            ADCSEQ_IDLE:
            begin
                if (next_r.go)
                begin
                    next_r.st = ADCSEQ_CONV;
                    next_r.div_cnt = 7'd0;
                    next_r.tad_idx = 4'd0;
                    next_r.trial = 10'h000;
                    next_r.mask = 10'h200;
                end
            end
            ADCSEQ_CONV:
            begin
                if (!next_r.go)
                begin
                    abort = 1'b1;
                    next_r.st = ADCSEQ_WAIT;
                    next_r.div_cnt = 7'd0;
                    next_r.tad_idx = 4'd0;
                end
                else if (tick)
                begin
                    next_r.tad_idx = r.tad_idx + 4'd1;
                    if (r.tad_idx == 4'd0)
                    begin
                        next_r.trial = r.mask;
                    end
                    else if (r.tad_idx == `ADCSEQ_CONV_TADS - 4'd1)
                    begin
                        // Load, release go, raise done
                        if (r.just)
                        begin
                            next_r.res_hi = {6'h00, r.trial[9:8]};
                            next_r.res_lo = r.trial[7:0];
                        end
                        else
                        begin
                            next_r.res_hi = r.trial[9:2];
                            next_r.res_lo = {r.trial[1:0], 6'h00};
                        end
                        next_r.go = 1'b0;
                        next_r.flags[`ADCSEQ_BIT_DONE] = 1'b1;
                        next_r.st = ADCSEQ_IDLE;
                    end
                    else
                    begin
                        // Keep the trial bit if input is above the DAC level
                        next_r.trial = (r.comp ? r.trial : (r.trial & ~r.mask))
                                     | (r.mask >> 1);
                        next_r.mask = r.mask >> 1;
                    end
                end
            end
            ADCSEQ_WAIT:
            begin
                if (tick)
                begin
                    next_r.tad_idx = r.tad_idx + 4'd1;
                    if (r.tad_idx == `ADCSEQ_ABORT_TADS - 4'd1)
                    begin
                        next_r.st = ADCSEQ_IDLE;
                    end
                end
            end
            default: next_r.st = ADCSEQ_IDLE;
        endcase

        // Set wins over a clear in the same cycle
        if (abort)
        begin
            next_r.flags[`ADCSEQ_BIT_ABORT] = 1'b1;
        end

        // Acquisition switch closed while idle and enabled; a late go waits out the abort gap
        next_r.sample = (next_r.st == ADCSEQ_IDLE) && next_r.en;
        next_r.irq = |(next_r.flags & next_r.enables);

        // Read data in the following cycle only
        if (RD)
        begin
            case (ADDR)
                `ADCSEQ_OFS_RES_HIGH: next_r.rdata = r.res_hi;
                `ADCSEQ_OFS_RES_LOW:  next_r.rdata = r.res_lo;
                `ADCSEQ_OFS_CTL_ZERO: next_r.rdata = {2'b00, r.chan, r.go, r.en};
                `ADCSEQ_OFS_CTL_ONE:  next_r.rdata = {2'b00, r.ctl1};
                `ADCSEQ_OFS_CTL_TWO:  next_r.rdata = {r.just, 4'h0, r.clksel};
                `ADCSEQ_OFS_FLAGS:    next_r.rdata = r.flags;
                `ADCSEQ_OFS_ENABLES:  next_r.rdata = r.enables;
                `ADCSEQ_OFS_PRIORITY: next_r.rdata = r.prio;
                default:              next_r.rdata = 8'h00;
            endcase
        end
    end

    // State register; reset stands for power-on, so the result clears too
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            r <= '0;
            r.prio <= `ADCSEQ_RST_PRIORITY;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign RDATA = r.rdata;
    assign TIMER_CLEAR = r.timer_clr;
    assign DAC_CODE = r.trial;
    assign SAMPLE = r.sample;
    assign CHANNEL = r.chan;
    assign IRQ = r.irq;
endmodule

// ---- verification/adcseq_ana_model.sv ----
// Analog input and sample-and-hold in front of the comparator
`timescale 1ns/100ps
module adcseq_ana_model
(
    input  wire logic [9:0] dac_code,
    input  wire logic       sample,
    input  wire logic [9:0] vin,
    output logic            comp_in
);
    logic [9:0] held;
    // Input is captured only while acquiring, so late changes never leak in
    always_latch
    begin
        if (sample)
            held = vin;
    end
    // Half a step above its code, so an equal trial keeps the bit
    assign comp_in = {held, 1'b1} > {dac_code, 1'b0};
endmodule

// ---- verification/adcseq_chk_asserts.sv ----
// Port-level checks of the conversion sequencer
`timescale 1ns/100ps
module adcseq_chk
(
    input wire logic       CORE_CLK,
    input wire logic       RST,
    input wire logic [3:0] ADDR,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       TRIG,
    input wire logic [3:0] COMPARE_MODE,
    input wire logic       TIMER_CLEAR,
    input wire logic       SAMPLE,
    input wire logic [3:0] CHANNEL,
    input wire logic       IRQ
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Bus answers last exactly one cycle
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property (RD && ADDR > 4'h8 |=> RDATA == 8'h00)
        else $error("unmapped index read not zero");
    a_clear_reads: assert property (RD && ADDR == 4'h8 |=> RDATA == 8'h00)
        else $error("clear register read not zero");
    a_ctl0_unused: assert property (RD && ADDR == 4'h2 |=> RDATA[7:6] == 2'b00)
        else $error("control zero upper bits set");
    a_ctl2_unused: assert property (RD && ADDR == 4'h4 |=> RDATA[6:3] == 4'h0)
        else $error("control two unused bits set");
    // Timer clear only follows a trigger in the compare mode
    a_tclr_cause: assert property (TIMER_CLEAR |-> $past(TRIG) && $past(COMPARE_MODE) == 4'hb)
        else $error("timer clear without trigger");
    a_tclr_fires: assert property (TRIG && COMPARE_MODE == 4'hb |=> TIMER_CLEAR)
        else $error("trigger did not clear timer");
    a_chan_cause: assert property ($changed(CHANNEL) |-> $past(WR) && $past(ADDR) == 4'h2)
        else $error("channel changed without write");
    c_trigger: cover property (TIMER_CLEAR);
    c_done: cover property ($rose(IRQ));
    c_acquire: cover property ($rose(SAMPLE));
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, trig = 1'b0;
    logic [3:0] addr = 4'h0, mode = 4'h0, chan;
    logic [7:0] wdata = 8'h00, rdata, q;
    logic [9:0] dac, vin = 10'h2a5;
    logic       tclr, comp, sample, irq;
    int         num_errors = 0, samples_checked = 0, cycles = 0, n;
    always #20 clk = ~clk;
    adcseq_top dut_u
    (
        .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TRIG(trig), .COMPARE_MODE(mode), .TIMER_CLEAR(tclr), .COMP_IN(comp), .DAC_CODE(dac),
        .SAMPLE(sample), .CHANNEL(chan), .IRQ(irq)
    );
    adcseq_ana_model ana_u (.dac_code(dac), .sample(sample), .vin(vin), .comp_in(comp));
    task chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp, msg);
    endtask
    // Bounded wait on the done interrupt; n counts edges since the start
    task wait_done;
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
            #1;
        end
        chk(irq, 1'b1, "conversion did not complete");
    endtask
    task t_reset;
        for (int a = 0; a < 10; a++)
            rd_chk(4'(a), (a == 7) ? 8'h7f : 8'h00, "reset value");
        wr_reg(4'h5, 8'hff);
        rd_chk(4'h5, 8'h00, "flags are read-only");
        $display("reset test done");
    endtask
    task t_enable;
        wr_reg(4'h2, 8'h02);
        rd_chk(4'h2, 8'h00, "go while disabled");
        wr_reg(4'h2, 8'h03);
        rd_chk(4'h2, 8'h01, "go in enabling write");
        $display("enable test done");
    endtask
    task t_clock;
        logic [2:0] code [8] = '{3'd0, 3'd4, 3'd1, 3'd5, 3'd2, 3'd6, 3'd3, 3'd7};
        int conversion_bit_period [8] = '{2, 4, 8, 16, 32, 64, 25, 25};
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(4'h4, {5'h00, code[i]});
            wr_reg(4'h8, 8'h41);
            wr_reg(4'h2, 8'h0b);
            wait_done();
            chk(10'(n), 10'(12 * conversion_bit_period[i]), "conversion length");
            rd_chk(4'h2, 8'h09, "go clears at completion");
            rd_chk(4'h5, 8'h40, "done flag sets");
        end
        $display("clock select test done");
    endtask
    task t_justify;
        logic [7:0] hi [2] = '{8'h02, 8'ha9};
        logic [7:0] lo [2] = '{8'ha5, 8'h40};
        for (int j = 0; j < 2; j++)
        begin
            wr_reg(4'h4, (j == 0) ? 8'h85 : 8'h05);
            wr_reg(4'h8, 8'h41);
            wr_reg(4'h2, 8'h0b);
            wait_done();
            rd_chk(4'h0, hi[j], "result high byte");
            rd_chk(4'h1, lo[j], "result low byte");
        end
        $display("justify test done");
    endtask
    task t_abort;
        vin = 10'h155;
        wr_reg(4'h8, 8'h41);
        wr_reg(4'h2, 8'h0b);
        repeat (40) @(posedge clk);
        wr_reg(4'h2, 8'h09);
        repeat (28) @(posedge clk);
        #1 chk(sample, 1'b0, "acquisition before wait ends");
        repeat (8) @(posedge clk);
        #1 chk(sample, 1'b1, "acquisition not restarted");
        chk(chan, 4'h2, "channel kept");
        rd_chk(4'h0, 8'ha9, "high byte after abort");
        rd_chk(4'h1, 8'h40, "low byte after abort");
        rd_chk(4'h5, 8'h01, "abort flag only");
        $display("abort test done");
    endtask
    task trig_chk(input logic [3:0] m, input logic clr, input logic [7:0] ctl);
        @(posedge clk);
        {trig, mode} <= {1'b1, m};
        @(posedge clk);
        trig <= 1'b0;
        #1 chk(tclr, clr, "timer clear");
        rd_chk(4'h2, ctl, "go after trigger");
    endtask
    task t_trig;
        wr_reg(4'h8, 8'h41);
        trig_chk(4'hb, 1'b1, 8'h0b);
        wait_done();
        trig_chk(4'ha, 1'b0, 8'h09);
        wr_reg(4'h2, 8'h08);
        trig_chk(4'hb, 1'b1, 8'h08);
        $display("trigger test done");
    endtask
    task t_irq;
        wr_reg(4'h6, 8'h00);
        #1 chk(irq, 1'b0, "masked interrupt");
        wr_reg(4'h6, 8'h40);
        #1 chk(irq, 1'b1, "enabled interrupt");
        wr_reg(4'h8, 8'h40);
        #1 chk(irq, 1'b0, "cleared interrupt");
        rd_chk(4'h5, 8'h00, "flags cleared");
        $display("interrupt test done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_enable();
        wr_reg(4'h6, 8'h40);
        t_clock();
        t_justify();
        t_abort();
        t_trig();
        t_irq();
        stop_test();
    end
endmodule
bind adcseq_top adcseq_chk chk_u
(
    .CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .TRIG(TRIG),
    .COMPARE_MODE(COMPARE_MODE), .TIMER_CLEAR(TIMER_CLEAR), .SAMPLE(SAMPLE), .CHANNEL(CHANNEL), .IRQ(IRQ)
);
